// >>> crb_core.sv
// dedicated cpu registers, status word, bank addressing, bus slave
`timescale 1ns/1ps
`default_nettype none
`include "crb_cfg.svh"
module crb_core #(
  parameter int        ADDR_W       = 8,
  parameter int        BANK_BITS    = 5,
  parameter logic [15:0] PROGRAM_BASE = 16'h8000
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // axi4-lite write channels
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read channels
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // sequencer register write port
  input  wire logic                core_write,
  input  wire crb_pkg::crb_reg_type core_sel,
  input  wire logic                core_byte,
  input  wire logic [15:0]         core_wdata,
  // program counter control
  input  wire logic                pc_load,
  input  wire logic                pc_step,
  input  wire logic [15:0]         pc_value,
  // alu result port
  input  wire crb_pkg::crb_op_type alu_op,
  input  wire logic                alu_sub,
  input  wire logic [7:0]          alu_a,
  input  wire logic [7:0]          alu_b,
  input  wire logic [7:0]          alu_data,
  input  wire logic                alu_shift_out,
  // banked register addressing
  input  wire logic [2:0]          opcode_low,
  output logic [15:0]              gpr_address,
  // interrupt gating
  input  wire logic                irq_request,
  input  wire logic [1:0]          irq_level,
  output logic                     irq_take,
  // memory area lookup
  input  wire logic [15:0]         probe_address,
  output crb_pkg::crb_area_type    probe_area,
  // register contents
  output logic [15:0]              program_counter,
  output logic [15:0]              working_sum,
  output logic [15:0]              second_operand,
  output logic [15:0]              offset_pointer,
  output logic [15:0]              memory_pointer,
  output logic [15:0]              stack_top,
  output logic [15:0]              cpu_status_word
);
  import crb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (ADDR_W < 5 || ADDR_W > 32) begin
    $error("crb_core: address width out of range");
  end
  if (BANK_BITS < 1 || BANK_BITS > 5) begin
    $error("crb_core: bank field must be 1 to 5 bits");
  end
  if (PROGRAM_BASE <= `CRB_IO_TOP) begin
    $error("crb_core: program area overlaps the io area");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]        bank_select;
  logic              irq_enable;
  logic [1:0]        priority_floor;
  logic              flag_carry;
  logic              flag_over;
  logic              flag_zero;
  logic              flag_sign;
  logic              flag_nibble;
  logic [7:0]        condition_flags;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic              wr_hit;
  logic              rd_hit;
  logic [15:0]       rd_word;
  logic              alu_commit;

  crb_flag_if flag_bus ();

  // flag computation for the current alu result
  crb_flag_unit flag_unit (
    .flags (flag_bus.unit)
  );

  assign flag_bus.op        = alu_op;
  assign flag_bus.sub       = alu_sub;
  assign flag_bus.a         = alu_a;
  assign flag_bus.b         = alu_b;
  assign flag_bus.data      = alu_data;
  assign flag_bus.shift_out = alu_shift_out;
  // arithmetic writes its result into the low accumulator byte
  assign alu_commit = (alu_op == crb_op_arith);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a bus word into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [15:0] merged;
    merged = old;
    if (strb[0])
      merged[7:0] = data[7:0];
    if (strb[1])
      merged[15:8] = data[15:8];
    return merged;
  endfunction

  // one aligned word per register
  function automatic logic offset_known(input logic [ADDR_W-1:0] addr);
    logic [7:0] byte_addr;
    byte_addr = 8'(addr);
    return (byte_addr == `CRB_OFF_PC) || (byte_addr == `CRB_OFF_SUM) ||
           (byte_addr == `CRB_OFF_SECOND) ||
           (byte_addr == `CRB_OFF_OFFSET) ||
           (byte_addr == `CRB_OFF_MEMPTR) ||
           (byte_addr == `CRB_OFF_STACK) ||
           (byte_addr == `CRB_OFF_STATUS);
  endfunction

  // bus write strobe for one register
  function automatic logic bus_hits(input logic [7:0] off);
    return wr_fire && wr_hit && (8'(aw_addr) == off);
  endfunction

  // sequencer write strobe for one register
  function automatic logic core_hits(input crb_reg_type sel);
    return core_write && (core_sel == sel);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit        = offset_known(aw_addr) &&
                         (aw_addr[1:0] == 2'h0);

  // hold address and data until both have arrived
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, slave error on an unmapped offset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CRB_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `CRB_RESP_OKAY : `CRB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit        = offset_known(s_axi_araddr) &&
                         (s_axi_araddr[1:0] == 2'h0);

  // register select for a read
  always_comb begin
    unique case (8'(s_axi_araddr))
      `CRB_OFF_PC:     rd_word = program_counter;
      `CRB_OFF_SUM:    rd_word = working_sum;
      `CRB_OFF_SECOND: rd_word = second_operand;
      `CRB_OFF_OFFSET: rd_word = offset_pointer;
      `CRB_OFF_MEMPTR: rd_word = memory_pointer;
      `CRB_OFF_STACK:  rd_word = stack_top;
      `CRB_OFF_STATUS: rd_word = cpu_status_word;
      default:         rd_word = 16'h0000;
    endcase
  end

  // read data and response, upper half reads zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `CRB_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_hit ? `CRB_RESP_OKAY : `CRB_RESP_SLVERR;
      s_axi_rdata  <= rd_hit ? {16'h0000, rd_word} : 32'h0000_0000;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter

  // load beats step; sequencer beats the bus
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      program_counter <= `CRB_RESET_PC;
    end else if (pc_load) begin
      program_counter <= pc_value;
    end else if (pc_step) begin
      program_counter <= program_counter + 16'h0001;   // wraps at top
    end else if (core_hits(crb_sel_pc)) begin
      program_counter <= core_wdata;
    end else if (bus_hits(`CRB_OFF_PC)) begin
      program_counter <= lane_merge(program_counter, w_data, w_strb);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulators, no reset so contents start undefined

  // working accumulator: alu result, then sequencer, then bus
  always_ff @(posedge clock) begin
    if (alu_commit) begin
      working_sum[7:0] <= flag_bus.result;
    end else if (core_hits(crb_sel_sum)) begin
      working_sum[7:0] <= core_wdata[7:0];
      if (!core_byte)
        working_sum[15:8] <= core_wdata[15:8];
    end else if (bus_hits(`CRB_OFF_SUM)) begin
      working_sum <= lane_merge(working_sum, w_data, w_strb);
    end
  end

  // second-operand accumulator
  always_ff @(posedge clock) begin
    if (core_hits(crb_sel_second)) begin
      second_operand[7:0] <= core_wdata[7:0];
      if (!core_byte)
        second_operand[15:8] <= core_wdata[15:8];
    end else if (bus_hits(`CRB_OFF_SECOND)) begin
      second_operand <= lane_merge(second_operand, w_data, w_strb);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointers, no reset so contents start undefined

  // index register
  always_ff @(posedge clock) begin
    if (core_hits(crb_sel_offset))
      offset_pointer <= core_wdata;
    else if (bus_hits(`CRB_OFF_OFFSET))
      offset_pointer <= lane_merge(offset_pointer, w_data, w_strb);
  end

  // memory pointer
  always_ff @(posedge clock) begin
    if (core_hits(crb_sel_memptr))
      memory_pointer <= core_wdata;
    else if (bus_hits(`CRB_OFF_MEMPTR))
      memory_pointer <= lane_merge(memory_pointer, w_data, w_strb);
  end

  // stack pointer
  always_ff @(posedge clock) begin
    if (core_hits(crb_sel_stack))
      stack_top <= core_wdata;
    else if (bus_hits(`CRB_OFF_STACK))
      stack_top <= lane_merge(stack_top, w_data, w_strb);
  end

  ////////////////////////////////////////////////////////////////////////
  // status word

  // bank select byte, undefined after reset
  always_ff @(posedge clock) begin
    if (core_hits(crb_sel_status))
      bank_select <= core_wdata[15:8];
    else if (bus_hits(`CRB_OFF_STATUS) && w_strb[1])
      bank_select <= w_data[15:8];
  end

  // interrupt control bits, defined by reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_enable     <= `CRB_RESET_IEN;
      priority_floor <= `CRB_RESET_FLOOR;
    end else if (core_hits(crb_sel_status)) begin
      irq_enable     <= core_wdata[`CRB_BIT_I];
      priority_floor <= core_wdata[`CRB_BIT_IL1:`CRB_BIT_IL0];
    end else if (bus_hits(`CRB_OFF_STATUS) && w_strb[0]) begin
      irq_enable     <= w_data[`CRB_BIT_I];
      priority_floor <= w_data[`CRB_BIT_IL1:`CRB_BIT_IL0];
    end
  end

  // result flags: alu update beats any write in the same cycle
  always_ff @(posedge clock) begin
    if (alu_op != crb_op_none) begin
      if (flag_bus.set_carry)
        flag_carry <= flag_bus.carry;
      if (flag_bus.set_over)
        flag_over <= flag_bus.overflow;
      if (flag_bus.set_nib)
        flag_nibble <= flag_bus.nibble;
      if (flag_bus.set_nz) begin
        flag_zero <= flag_bus.zero;
        flag_sign <= flag_bus.sign;
      end
    end else if (core_hits(crb_sel_status)) begin
      flag_carry  <= core_wdata[`CRB_BIT_C];
      flag_over   <= core_wdata[`CRB_BIT_V];
      flag_zero   <= core_wdata[`CRB_BIT_Z];
      flag_sign   <= core_wdata[`CRB_BIT_N];
      flag_nibble <= core_wdata[`CRB_BIT_H];
    end else if (bus_hits(`CRB_OFF_STATUS) && w_strb[0]) begin
      flag_carry  <= w_data[`CRB_BIT_C];
      flag_over   <= w_data[`CRB_BIT_V];
      flag_zero   <= w_data[`CRB_BIT_Z];
      flag_sign   <= w_data[`CRB_BIT_N];
      flag_nibble <= w_data[`CRB_BIT_H];
    end
  end

  // assemble the condition flag byte
  always_comb begin
    condition_flags                               = 8'h00;
    condition_flags[`CRB_BIT_C]                   = flag_carry;
    condition_flags[`CRB_BIT_V]                   = flag_over;
    condition_flags[`CRB_BIT_Z]                   = flag_zero;
    condition_flags[`CRB_BIT_N]                   = flag_sign;
    condition_flags[`CRB_BIT_IL1:`CRB_BIT_IL0]    = priority_floor;
    condition_flags[`CRB_BIT_I]                   = irq_enable;
    condition_flags[`CRB_BIT_H]                   = flag_nibble;
  end

  assign cpu_status_word = {bank_select, condition_flags};

  ////////////////////////////////////////////////////////////////////////
  // banked register address and interrupt gate

  // fixed prefix, bank field, low opcode bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      gpr_address <= 16'h0000;
    else
      gpr_address <= {`CRB_GPR_PREFIX,
                      {(5-BANK_BITS){1'b0}},
                      bank_select[BANK_BITS-1:0],
                      opcode_low};
  end

  // admit only a level numerically below the floor
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      irq_take <= 1'b0;
    else
      irq_take <= irq_enable && irq_request &&
                  (irq_level < priority_floor);
  end

  ////////////////////////////////////////////////////////////////////////
  // memory area lookup over the single 64 Kbyte space

  // io lowest, data above it, program and vectors at the top
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      probe_area <= crb_area_io;
    else if (probe_address <= `CRB_IO_TOP)
      probe_area <= crb_area_io;
    else if (probe_address < PROGRAM_BASE)
      probe_area <= crb_area_data;
    else
      probe_area <= crb_area_program;
  end
endmodule // crb_core
`default_nettype wire

// >>> crb_cfg.svh
// constants for the cpu status and register bank block
// Functional notes
// - one 64 Kbyte space, I/O lowest, data above
// - program area and vectors at top of space
// - 16-bit program counter, reset value fffd
// - 16-bit accumulators; 8-bit ops use low byte
// - pointers and accumulators not reset
// - status word: bank select high, flags low
// - bank address is 0000000 1 bank opcode
// - eight registers per bank, 32 banks
// - nibble flag is carry between bits 3, 4
// - interrupt enable flag, cleared by reset
// - priority floor admits higher levels, resets 11
// - sign flag follows result msb
// - zero flag set on zero result
// - overflow flag on signed range overflow
// - carry from bit 7; shifts load shifted bit
`ifndef CRB_CFG_SVH
`define CRB_CFG_SVH
// register byte offsets on the bus
`define CRB_OFF_PC     8'h00
`define CRB_OFF_SUM    8'h04
`define CRB_OFF_SECOND 8'h08
`define CRB_OFF_OFFSET 8'h0c
`define CRB_OFF_MEMPTR 8'h10
`define CRB_OFF_STACK  8'h14
`define CRB_OFF_STATUS 8'h18
// reset values
`define CRB_RESET_PC    16'hfffd
`define CRB_RESET_IEN   1'h0
`define CRB_RESET_FLOOR 2'h3
// condition flag bit positions in the low byte
`define CRB_BIT_C   0
`define CRB_BIT_V   1
`define CRB_BIT_Z   2
`define CRB_BIT_N   3
`define CRB_BIT_IL0 4
`define CRB_BIT_IL1 5
`define CRB_BIT_I   6
`define CRB_BIT_H   7
// banked register address prefix above the bank field
`define CRB_GPR_PREFIX 8'h01
// memory map boundaries
`define CRB_IO_TOP 16'h007f
// bus responses
`define CRB_RESP_OKAY   2'h0
`define CRB_RESP_SLVERR 2'h2
`endif

// >>> crb_pkg.sv
// types shared by the cpu status and register bank block
package crb_pkg;
  // what the sequencer did in this cycle
  typedef enum logic [1:0] {
    crb_op_none, crb_op_arith, crb_op_transfer, crb_op_shift
  } crb_op_type;
  // register chosen by the sequencer write port
  typedef enum logic [2:0] {
    crb_sel_pc, crb_sel_sum, crb_sel_second, crb_sel_offset,
    crb_sel_memptr, crb_sel_stack, crb_sel_status
  } crb_reg_type;
  // memory area of an address
  typedef enum logic [1:0] {
    crb_area_io, crb_area_data, crb_area_program
  } crb_area_type;
endpackage

// >>> crb_flag_if.sv
// carrier between the register block and its flag unit
`timescale 1ns/1ps
`default_nettype none
interface crb_flag_if;
  import crb_pkg::*;
  crb_op_type op;
  logic       sub;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] data;
  logic       shift_out;
  logic [7:0] result;
  logic       carry;
  logic       overflow;
  logic       zero;
  logic       sign;
  logic       nibble;
  logic       set_carry;
  logic       set_over;
  logic       set_nib;
  logic       set_nz;
  modport core (output op, sub, a, b, data, shift_out,
                input result, carry, overflow, zero, sign, nibble,
                input set_carry, set_over, set_nib, set_nz);
  modport unit (input op, sub, a, b, data, shift_out,
                output result, carry, overflow, zero, sign, nibble,
                output set_carry, set_over, set_nib, set_nz);
endinterface
`default_nettype wire

// >>> crb_flag_unit.sv
// condition flag computation for 8-bit results
`timescale 1ns/1ps
`default_nettype none
module crb_flag_unit (
  // flag request and answer
  crb_flag_if.unit flags
);
  import crb_pkg::*;
  logic [8:0] wide;
  logic [4:0] half;

  // add or subtract with carry out of bit 7 and bit 3
  always_comb begin
    if (flags.sub) begin
      wide = {1'b0, flags.a} - {1'b0, flags.b};
      half = {1'b0, flags.a[3:0]} - {1'b0, flags.b[3:0]};
    end else begin
      wide = {1'b0, flags.a} + {1'b0, flags.b};
      half = {1'b0, flags.a[3:0]} + {1'b0, flags.b[3:0]};
    end
  end

  // result and flag values per kind of operation
  always_comb begin
    flags.result    = flags.data;
    flags.nibble    = half[4];
    flags.overflow  = 1'b0;
    flags.carry     = flags.shift_out;
    flags.set_carry = 1'b0;
    flags.set_over  = 1'b0;
    flags.set_nib   = 1'b0;
    flags.set_nz    = 1'b0;
    unique case (flags.op)
      crb_op_none: begin
        flags.result = flags.data;
      end
      crb_op_arith: begin
        flags.result    = wide[7:0];
        flags.carry     = wide[8];
        flags.overflow  = flags.sub ?
          (flags.a[7] != flags.b[7]) && (wide[7] != flags.a[7]) :
          (flags.a[7] == flags.b[7]) && (wide[7] != flags.a[7]);
        flags.set_carry = 1'b1;
        flags.set_over  = 1'b1;
        flags.set_nib   = 1'b1;
        flags.set_nz    = 1'b1;
      end
      crb_op_transfer: begin
        flags.set_nz = 1'b1;
      end
      crb_op_shift: begin
        flags.set_carry = 1'b1;
        flags.set_nz    = 1'b1;
      end
    endcase
    flags.sign = flags.result[7];
    flags.zero = (flags.result == 8'h00);
  end
endmodule // crb_flag_unit
`default_nettype wire

// >>> crb_monitor.sv
// checker for the cpu status and register bank block
`timescale 1ns/1ps
`default_nettype none
module crb_monitor (
  // clock and reset
  input wire logic                clock,
  input wire logic                rst,
  // bus and sequencer
  input wire logic                s_axi_bvalid,
  input wire logic                core_write,
  input wire crb_pkg::crb_op_type alu_op,
  input wire logic                alu_sub,
  input wire logic [7:0]          alu_a,
  input wire logic [7:0]          alu_b,
  input wire logic [7:0]          alu_data,
  input wire logic                alu_shift_out,
  // addressing, interrupts, registers
  input wire logic [2:0]          opcode_low,
  input wire logic [15:0]         gpr_address,
  input wire logic                irq_request,
  input wire logic [1:0]          irq_level,
  input wire logic                irq_take,
  input wire logic [15:0]         program_counter,
  input wire logic [15:0]         working_sum,
  input wire logic [15:0]         cpu_status_word
);
  import crb_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // adder views of the operands
  wire logic [8:0] add9 = alu_a + alu_b;
  wire logic [4:0] add5 = alu_a[3:0] + alu_b[3:0];
  //////////////////////////////////////////////////////////////////////
  AST_RESET_VALUES: assert property (disable iff (1'b0)
    $fell(rst) |-> program_counter == 16'hfffd
      && cpu_status_word[6:4] == 3'h3) else $error("bad reset values");
  AST_GPR_ADDR: assert property ($past(!rst) |->
    gpr_address[15:8] == 8'h01 && gpr_address[2:0] == $past(opcode_low))
    else $error("bank address wrong");
  AST_IRQ_GATE: assert property ($past(!rst) |-> irq_take ==
    $past(cpu_status_word[6] && irq_request
      && irq_level < cpu_status_word[5:4])) else $error("irq gate wrong");
  AST_IRQ_LOWEST: assert property (irq_level == 2'h3 |=> !irq_take)
    else $error("lowest level admitted");
  AST_ADD_SUM: assert property (alu_op == crb_op_arith && !alu_sub |=>
    working_sum[7:0] == $past(add9[7:0])
      && cpu_status_word[2] == ($past(add9[7:0]) == 8'h00))
    else $error("sum or zero flag wrong");
  AST_ADD_CARRY: assert property (alu_op == crb_op_arith && !alu_sub |=>
    cpu_status_word[0] == $past(add9[8])
      && cpu_status_word[7] == $past(add5[4])) else $error("carry wrong");
  AST_TRANSFER: assert property (alu_op == crb_op_transfer |=>
    cpu_status_word[3] == $past(alu_data[7])
      && cpu_status_word[2] == ($past(alu_data) == 8'h00))
    else $error("transfer flags wrong");
  AST_SHIFT: assert property (alu_op == crb_op_shift |=>
    cpu_status_word[0] == $past(alu_shift_out)) else $error("shift carry");
  AST_KEEP: assert property ($past(alu_op) == crb_op_arith
    && alu_op == crb_op_none && !core_write
    |=> $rose(s_axi_bvalid) || $stable(cpu_status_word[7:0]))
    else $error("flags changed without operation");
  // main scenarios
  cover property (alu_op == crb_op_arith && alu_sub);
  cover property (irq_take);
  cover property (alu_op == crb_op_shift);
endmodule // crb_monitor
bind crb_core crb_monitor u_mon (.*);
`default_nettype wire

// >>> testbench.sv
// self-checking testbench for the cpu status and register bank block
`timescale 1ns/1ps
`default_nettype none
`include "crb_cfg.svh"
module testbench;
  import crb_pkg::*;
  logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, core_write, core_byte, pc_load;
  logic pc_step, alu_sub, alu_shift_out, irq_request, irq_take;
  logic [7:0] s_axi_awaddr, s_axi_araddr, alu_a, alu_b, alu_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, irq_level;
  logic [2:0] opcode_low;
  logic [15:0] core_wdata, pc_value, gpr_address, probe_address;
  logic [15:0] program_counter, working_sum, second_operand;
  logic [15:0] offset_pointer, memory_pointer, stack_top, cpu_status_word;
  crb_reg_type core_sel = crb_sel_pc;
  crb_op_type alu_op = crb_op_none;
  crb_area_type probe_area;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] d;
  logic [1:0] r;
  crb_core u_dut (.*);
  // clock
  always #5 clock = ~clock;
  //////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bus write: address and data together, hold each until taken
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // bus read
  task axi_rd(input logic [7:0] a);
    @(posedge clock);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // one alu cycle, sampled just after its effect lands
  task alu(input crb_op_type op, input logic [16:0] sab, input logic [8:0] ds);
    @(posedge clock);
    alu_op <= op;
    {alu_sub, alu_a, alu_b} <= sab;
    {alu_data, alu_shift_out} <= ds;
    @(posedge clock);
    alu_op <= crb_op_none;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_regs;
    axi_rd(`CRB_OFF_PC);
    check("pc_reset", 32'h0000fffd, d);
    axi_rd(`CRB_OFF_STATUS);
    check("i_floor", 32'h3, {29'h0, d[6:4]});
    for (int i = 0; i < 7; i++) begin
      axi_wr(8'(4 * i), {16'hffff, 16'ha5c0 + 16'(i)});
      check("wr_resp", 32'h0, {30'h0, r});
      axi_rd(8'(4 * i));
      check("reg", {16'h0, 16'ha5c0 + 16'(i)}, d);
    end
    axi_wr(8'h1c, 32'h1);
    check("bad_wr", {30'h0, `CRB_RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h1c);
    check("bad_rd", {30'h0, 2'h2}, {d[29:0], r});
  endtask
  task t_bank;
    for (int b = 0; b < 32; b++) begin
      axi_wr(`CRB_OFF_STATUS, {19'h0, 5'(b), 8'h00});
      @(posedge clock);
      opcode_low <= 3'(b + 3);
      @(posedge clock);
      #1;
      check("gpr", {16'h01, 5'(b), 3'(b + 3)}, {16'h0, gpr_address});
    end
  endtask
  task t_alu;
    logic [16:0] tc [5] = '{17'h00f01, 17'h07f01, 17'h0ff01, 17'h10001, 17'h18001};
    logic [8:0] s9;
    logic [4:0] h5;
    logic [7:0] f;
    for (int i = 0; i < 5; i++) begin
      s9 = tc[i][16] ? tc[i][15:8] - tc[i][7:0] : tc[i][15:8] + tc[i][7:0];
      h5 = tc[i][16] ? tc[i][11:8] - tc[i][3:0] : tc[i][11:8] + tc[i][3:0];
      f = {h5[4], 3'h0, s9[7], s9[7:0] == 8'h00, (tc[i][15] ^ s9[7])
        && (tc[i][16] ^ tc[i][15] ^~ tc[i][7]), s9[8]};
      alu(crb_op_arith, tc[i], 9'h0);
      check("sum", {24'ha5, s9[7:0]}, {16'h0, working_sum});
      check("flags", {24'h0, f}, {24'h0, cpu_status_word[7:0] & 8'h8f});
    end
    alu(crb_op_shift, 17'h0, 9'h001);
    check("shift", 32'h3, {29'h0, cpu_status_word[3:2], cpu_status_word[0]});
    alu(crb_op_transfer, 17'h0, 9'h100);
    f = cpu_status_word[7:0];
    check("xfer", 32'h5, {29'h0, f[3:2], f[0]});
    @(posedge clock);
    core_sel <= crb_sel_stack;
    {core_wdata, core_write} <= {16'h1234, 1'b1};
    @(posedge clock);
    core_write <= 1'b0;
    #1;
    check("keep", {16'h1234, 8'h0, f}, {stack_top, 8'h0, cpu_status_word[7:0]});
  endtask
  task t_irq;
    for (int k = 0; k < 32; k++) begin
      if (k % 4 == 0) axi_wr(`CRB_OFF_STATUS, {25'h0, k[4], k[3:2], 4'h0});
      @(posedge clock);
      {irq_request, irq_level} <= {1'b1, k[1:0]};
      @(posedge clock);
      #1;
      check("irq", {31'h0, k[4] && k[1:0] < k[3:2]}, {31'h0, irq_take});
    end
  endtask
  task t_area;
    logic [15:0] ad [6] = '{16'h0, 16'h7f, 16'h80, 16'h7fff, 16'h8000, 16'hffff};
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      probe_address <= ad[i];
      @(posedge clock);
      #1;
      check("area", {30'h0, 2'(i / 2)}, {30'h0, probe_area});
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h08;
    {s_axi_arvalid, s_axi_rready, core_write, core_byte, pc_load} = '0;
    {pc_step, alu_sub, alu_shift_out, irq_request, irq_level} = '0;
    {s_axi_awaddr, s_axi_araddr, alu_a, alu_b, alu_data, s_axi_wdata} = '0;
    {core_wdata, pc_value, probe_address, opcode_low} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_bank;
    t_alu;
    t_irq;
    t_area;
    report_and_stop;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
